// [src/fsl_regs.vh]
// constants for the feature serial loader
`ifndef FSL_REGS_VH
`define FSL_REGS_VH
`define FSL_FEAT_W 18
`define FSL_CAL_W 17
`define FSL_CNT_W 5
`define FSL_HOLD_W 24
`define FSL_STEP_PULSES 2'h2
`define FSL_CHV_MSB 17
`define FSL_CHV_LSB 13
`define FSL_SENS_MSB 12
`define FSL_SENS_LSB 9
`define FSL_HYS_MSB 8
`define FSL_HYS_LSB 6
`define FSL_STBY_MSB 5
`define FSL_STBY_LSB 1
`define FSL_STORE_MS 10
`define FSL_CLK_KHZ 10000
`endif

// [src/fsl_sync.v]
// two-flop synchroniser with edge detect taken from the second stage
`timescale 1ns/1ps
module fsl_sync (
  input wire clk_in,
  input wire rst_b_in,
  input wire d_in,
  output reg q_out,
  output reg rise_out,
  output reg fall_out
);
  reg meta_reg;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b0;
      q_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
      rise_out <= meta_reg & ~q_out;
      fall_out <= ~meta_reg & q_out;
    end
  end
endmodule

// [src/fsl_loader.v]
// serial feature word loader with mode entry and store strobe
`timescale 1ns/1ps
`include "fsl_regs.vh"
// What this block does
// RULE1: data pin sampled on shift clock edges, word later written to memory
// RULE2: programmer holds pins low at power-up; device starts in normal mode
// RULE3: mode step rising and held high enters entry mode
// RULE4: with data high, two mode step pulses enter feature load mode
// RULE5: exactly 18 bits shifted in, one per shift clock pulse; with cal_load_in high the loader takes 17
// RULE6: store strobe high of at least 10 ms commits the word
// RULE7: changing settings needs power down and full re-entry of bits
// RULE8: calibration bits 17..13 form chamber voltage trim, 17 is msb
// RULE9: calibration bits 12..9 form sensitivity trim, 12 is msb
// RULE10: calibration bits 8..6 form hysteresis trim, 8 is msb
// RULE11: calibration fields shifted lsb first, standby field lowest
// RULE12: shift clocks outside load mode ignored; memory kept until valid store
module fsl_loader #(
  parameter FEAT_W = `FSL_FEAT_W,
  parameter CAL_W = `FSL_CAL_W,
  parameter STORE_CYC = (`FSL_STORE_MS * `FSL_CLK_KHZ)
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire mode_step_pin_in,
  input wire serial_data_in,
  input wire shift_clock_in,
  input wire store_strobe_in,
  input wire cal_load_in,
  output wire normal_mode_out,
  output wire entry_mode_out,
  output wire feature_load_mode_out,
  output reg [FEAT_W-1:0] feature_word_out,
  output reg store_done_out,
  output reg [4:0] chamber_voltage_trim_out,
  output reg [3:0] four_bit_sensitivity_trim_out,
  output reg [2:0] hysteresis_trim_out,
  output reg [4:0] standby_sensitivity_trim_out
);
  localparam ST_NORMAL = 4'h1;
  localparam ST_ENTRY = 4'h2;
  localparam ST_LOAD = 4'h4;
  localparam ST_DONE = 4'h8;
  localparam HOLD_W = `FSL_HOLD_W;
  localparam CNT_W = `FSL_CNT_W;

  // the step, data, shift clock and strobe pins are asynchronous to clk_in and pass two flops first; cal_load_in is used directly
  wire step_q;
  wire step_rise;
  wire data_q;
  wire sck_rise;
  wire stb_q;

  fsl_sync u_step (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(mode_step_pin_in),
    .q_out(step_q),
    .rise_out(step_rise),
    .fall_out()
  );

  fsl_sync u_data (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(serial_data_in),
    .q_out(data_q),
    .rise_out(),
    .fall_out()
  );

  fsl_sync u_sck (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(shift_clock_in),
    .q_out(),
    .rise_out(sck_rise),
    .fall_out()
  );

  fsl_sync u_stb (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(store_strobe_in),
    .q_out(stb_q),
    .rise_out(),
    .fall_out()
  );

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [1:0] pulse_reg;
  reg [FEAT_W-1:0] shift_reg;
  reg [CNT_W-1:0] bits_reg;
  reg [HOLD_W-1:0] hold_reg;
  reg hold_ok_reg;
  reg [CAL_W-1:0] cal_shift_reg;

  assign normal_mode_out = state_reg[0];
  assign entry_mode_out = state_reg[1];
  assign feature_load_mode_out = state_reg[2];

  wire in_load;
  wire in_entry;
  wire [CNT_W-1:0] word_len;
  wire bits_full;
  wire sck_take;
  wire hold_met;
  wire store_fire;

  assign in_load = (state_reg == ST_LOAD);
  assign in_entry = (state_reg == ST_ENTRY);
  // a calibration stream is one bit shorter than a feature word
  assign word_len = cal_load_in ? CAL_W[CNT_W-1:0] : FEAT_W[CNT_W-1:0];
  assign bits_full = (bits_reg == word_len);
  // clocks outside load mode or past the last bit are dropped
  assign sck_take = in_load && sck_rise && !bits_full; // RULE12 RULE5
  assign hold_met = (hold_reg == STORE_CYC[HOLD_W-1:0]);
  // commit on strobe fall, only after a full word and a long enough high
  assign store_fire = in_load && !stb_q && hold_ok_reg && bits_full; // RULE6

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL:
        if (step_rise) state_next = ST_ENTRY; // RULE3 RULE2
      ST_ENTRY:
        if (!data_q && !step_q) state_next = ST_NORMAL;
        else if (step_rise && data_q && pulse_reg == `FSL_STEP_PULSES - 2'h1)
          state_next = ST_LOAD; // RULE4
      ST_LOAD:
        if (store_done_out) state_next = ST_DONE;
      ST_DONE:
        state_next = ST_DONE; // RULE7
      default:
        state_next = ST_NORMAL;
    endcase
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_NORMAL; // RULE2
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulse_reg <= 2'h0;
    end else if (in_entry && step_rise && data_q) begin
      pulse_reg <= pulse_reg + 2'h1; // RULE4
    end else if (!in_entry) begin
      pulse_reg <= 2'h0;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bits_reg <= {CNT_W{1'b0}};
    end else if (sck_take) begin
      bits_reg <= bits_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE5
    end
  end

  // msb first into the bottom and shifted up, so the first bit ends at the highest index
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_reg <= {FEAT_W{1'b0}};
    end else if (sck_take) begin
      shift_reg <= {shift_reg[FEAT_W-2:0], data_q}; // RULE1 RULE5
    end
  end

  // counter saturates so a very long strobe cannot wrap and look short
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_reg <= {HOLD_W{1'b0}};
    end else if (in_load && stb_q) begin
      if (!hold_met) begin
        hold_reg <= hold_reg + {{(HOLD_W-1){1'b0}}, 1'b1};
      end
    end else begin
      hold_reg <= {HOLD_W{1'b0}};
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_ok_reg <= 1'b0;
    end else if (in_load && stb_q) begin
      if (hold_met) begin
        hold_ok_reg <= 1'b1; // RULE6
      end
    end else begin
      hold_ok_reg <= 1'b0;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      store_done_out <= 1'b0;
    end else begin
      store_done_out <= store_fire; // RULE6
    end
  end

  // stored word stands for the memory; only a feature store touches it
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      feature_word_out <= {FEAT_W{1'b0}};
    end else if (store_fire && !cal_load_in) begin
      feature_word_out <= shift_reg; // RULE1 RULE12
    end
  end

  // calibration word: lsb-first field stream shifts in from the top
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_shift_reg <= {CAL_W{1'b0}};
      chamber_voltage_trim_out <= 5'h00;
      four_bit_sensitivity_trim_out <= 4'h0;
      hysteresis_trim_out <= 3'h0;
      standby_sensitivity_trim_out <= 5'h00;
    end else begin
      if (cal_load_in && sck_take)
        cal_shift_reg <= {data_q, cal_shift_reg[CAL_W-1:1]}; // RULE11 RULE12
      if (cal_load_in && store_done_out) begin
        chamber_voltage_trim_out <=
          cal_shift_reg[`FSL_CHV_MSB-1:`FSL_CHV_LSB-1]; // RULE8
        four_bit_sensitivity_trim_out <=
          cal_shift_reg[`FSL_SENS_MSB-1:`FSL_SENS_LSB-1]; // RULE9
        hysteresis_trim_out <=
          cal_shift_reg[`FSL_HYS_MSB-1:`FSL_HYS_LSB-1]; // RULE10
        standby_sensitivity_trim_out <=
          cal_shift_reg[`FSL_STBY_MSB-1:`FSL_STBY_LSB-1]; // RULE11
      end
    end
  end
endmodule

// [testbench/fsl_loader_properties.sv]
// checker for loader modes, the store pulse and held outputs
`timescale 1ns/1ps
module fsl_loader_checker #(parameter FEAT_W = 18) (
  input wire clk_in,
  input wire rst_b_in,
  input wire mode_step_pin_in,
  input wire normal_mode_out,
  input wire entry_mode_out,
  input wire feature_load_mode_out,
  input wire [FEAT_W-1:0] feature_word_out,
  input wire store_done_out,
  input wire [4:0] chamber_voltage_trim_out
);
  wire [2:0] m = {normal_mode_out, entry_mode_out, feature_load_mode_out};
  wire s = mode_step_pin_in;
  wire d = store_done_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_one_hot: assert property ($onehot0(m)) else $error("modes");
  a_stay_normal: assert property ((m[2] && !s) [*5] |=> m[2])
    else $error("left normal");
  a_entry_cause: assert property ($rose(m[1]) && $past(m[2])
    |-> $past(s, 3)) else $error("entry");
  a_load_cause: assert property ($rose(m[0]) |-> $past(m[1]))
    else $error("load");
  a_done_once: assert property (d |=> !d [*8]) else $error("pulse");
  a_done_state: assert property (d |-> !m[2] && !m[1])
    else $error("done");
  a_word_held: assert property ($changed(feature_word_out)
    |-> (d || $past(d)) or ##1 d) else $error("word");
  a_trim_held: assert property ($changed(chamber_voltage_trim_out)
    |-> (d || $past(d)) or ##1 d) else $error("trim");
  c_load: cover property (m[0]);
  c_store: cover property (d);
  c_entry: cover property ($rose(m[1]));
endmodule
bind fsl_loader fsl_loader_checker #(.FEAT_W(FEAT_W)) u_chk (.clk_in,
  .rst_b_in, .mode_step_pin_in, .normal_mode_out, .entry_mode_out,
  .feature_load_mode_out, .feature_word_out, .store_done_out,
  .chamber_voltage_trim_out);

// [testbench/fsl_programmer.sv]
// programmer model driving the loader's mode, data and store pins
`timescale 1ns/1ps
module fsl_programmer (
  input wire clk_in,
  output reg step_out,
  output reg data_out,
  output reg sck_out,
  output reg strobe_out
);
  integer i;
  initial {step_out, data_out, sck_out, strobe_out} = 4'h0;
  task idle;
    begin
      {step_out, data_out, sck_out, strobe_out} <= 4'h0;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task enter_load;
    begin
      cyc(1);
      step_out <= 1'b1;
      cyc(8);
      data_out <= 1'b1;
      repeat (2) begin
        cyc(8);
        step_out <= 1'b0;
        cyc(8);
        step_out <= 1'b1;
      end
      cyc(8);
    end
  endtask
  // clock idles low between frames; released data shows the inverse
  task shift(input [17:0] w, input integer n, input lsb);
    begin
      cyc(1);
      for (i = 0; i < n; i = i + 1) begin
        data_out <= lsb ? w[i] : w[n-1-i];
        cyc(4);
        sck_out <= 1'b1;
        cyc(4);
        sck_out <= 1'b0;
      end
      data_out <= ~data_out;
    end
  endtask
  task store(input integer n);
    begin
      strobe_out <= 1'b1;
      cyc(n);
      strobe_out <= 1'b0;
      cyc(1);
    end
  endtask
endmodule

// [testbench/fsl_loader_bench.sv]
// bench for the feature serial loader
`timescale 1ns/1ps
module fsl_loader_bench;
  reg clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg cal = 1'b0;
  wire st, sd, sk, sb, n, e, l, dn;
  wire [17:0] w;
  wire [4:0] cv, sy;
  wire [3:0] se;
  wire [2:0] hy;
  integer num_errors = 0;
  integer comparisons = 0;
  integer i;
  always #50 clk_in = ~clk_in;
  fsl_programmer u_prog (.clk_in(clk_in), .step_out(st), .data_out(sd),
    .sck_out(sk), .strobe_out(sb));
  fsl_loader #(.STORE_CYC(20)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .mode_step_pin_in(st), .serial_data_in(sd), .shift_clock_in(sk),
    .store_strobe_in(sb), .cal_load_in(cal), .normal_mode_out(n),
    .entry_mode_out(e), .feature_load_mode_out(l), .feature_word_out(w),
    .store_done_out(dn), .chamber_voltage_trim_out(cv),
    .four_bit_sensitivity_trim_out(se), .hysteresis_trim_out(hy),
    .standby_sensitivity_trim_out(sy));
  task check(input [47:0] nm, input [17:0] x, input [17:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== x) begin
        num_errors = num_errors + 1;
        $display("Error %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wait_done(input x);
    reg seen;
    begin
      seen = 1'b0;
      for (i = 0; i < 40 && !seen; i = i + 1) begin
        @(negedge clk_in);
        seen = (dn === 1'b1);
      end
      check("done", {17'h0, x}, {17'h0, seen});
      if (x && !seen)
        give_verdict;
    end
  endtask
  task do_reset;
    begin
      rst_b_in <= 1'b0;
      u_prog.idle;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
  endtask
  task test_feature; // stray clocks, surplus bits, short strobe
    begin
      do_reset;
      @(negedge clk_in);
      check("normal", 18'h4, {15'h0, n, e, l});
      u_prog.shift(18'h3FFFF, 4, 1'b0);
      u_prog.enter_load;
      @(negedge clk_in);
      check("load", 18'h1, {15'h0, n, e, l});
      u_prog.shift(18'h2B5A7, 18, 1'b0);
      u_prog.shift(18'h3FFFF, 3, 1'b0);
      u_prog.store(10);
      wait_done(1'b0);
      check("word", 18'h0, w);
      u_prog.store(25);
      wait_done(1'b1);
      check("word", 18'h2B5A7, w);
      @(negedge clk_in);
      check("modes", 18'h0, {15'h0, n, e, l});
    end
  endtask
  task test_cal; // fresh power-up, calibration stream lsb first
    begin
      do_reset;
      cal <= 1'b1;
      u_prog.enter_load;
      u_prog.shift({1'b0, 5'h13, 4'hA, 3'h5, 5'h0C}, 17, 1'b1);
      u_prog.store(25);
      wait_done(1'b1);
      @(negedge clk_in);
      check("word", 18'h0, w);
      check("chv", 18'h13, {13'h0, cv});
      check("sens", 18'hA, {14'h0, se});
      check("hys", 18'h5, {15'h0, hy});
      check("stby", 18'hC, {13'h0, sy});
    end
  endtask
  initial begin
    test_feature;
    test_cal;
    give_verdict;
  end
endmodule
